// File: verilog/framer_params.svh
// Purpose: constants of the authentication order word framer
// Assumes: one word per register slot, 32-bit classic bus
// Notes:   offsets are byte addresses
`ifndef FRAMER_PARAMS_SVH
`define FRAMER_PARAMS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_CMD        8'h00
`define OFS_FIELDS     8'h04
`define OFS_CHAL       8'h08
`define OFS_UPD_HI     8'h0C
`define OFS_UPD_MID    8'h10
`define OFS_UPD_LO     8'h14
`define OFS_PARITY     8'h18
`define OFS_STATUS     8'h1C

// ------------------------------------------------------------
// field widths
// ------------------------------------------------------------
`define W_TYPE         2
`define W_COLOR        2
`define W_ACT          4
`define W_OHD          3
`define W_CHAL         32
`define W_CHAL_LOW     16
`define W_UPD_PART     24
`define W_UPD_LOW      8
`define W_RSVD_A       12
`define W_RSVD_B       4
`define W_FIELDS       8
`define W_CMD          4
`define W_INFO         28
`define W_PAR          12
`define W_WORD         40
`define W_KIND         2
`define FIFO_DEPTH     16
`define W_LEVEL        5

// ------------------------------------------------------------
// codes and field positions
// ------------------------------------------------------------
`define OHD_GLOBAL     3'h4
`define OHD_SYS_FIRST  3'h6
`define OHD_SYS_SECOND 3'h7
`define PARITY_POLY    12'hB4F
`define CMD_GO_BIT     0
`define CMD_KIND_LSB   1
`define CMD_END_BIT    3
`define ST_BUSY_BIT    0
`define ST_ERR_BIT     1
`define ST_LEVEL_LSB   4
`define FLD_COLOR_LSB  2
`define FLD_ACT_LSB    4

`endif

// File: verilog/framer_pkg.sv
// Purpose: types of the authentication order word framer
// Assumes: framer_params.svh on the include path
// Notes:   state of the top is one packed struct
package framer_pkg;
  `include "framer_params.svh"

  typedef enum logic [1:0]
  {
    KIND_CHAL_B  = 2'h0,
    KIND_UPD_ONE = 2'h1,
    KIND_UPD_TWO = 2'h2,
    KIND_UPD_THR = 2'h3
  } word_kind_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h1,
    ST_PUSH = 2'h2
  } framer_fsm_t;

  typedef struct packed {
    framer_fsm_t              st;
    logic                     ack;
    logic [31:0]              rdat;
    logic [`W_TYPE-1:0]       type_code;
    logic [`W_COLOR-1:0]      color;
    logic [`W_ACT-1:0]        act;
    logic [`W_CHAL-1:0]       chal;
    logic [`W_UPD_PART-1:0]   upd_hi;
    logic [`W_UPD_PART-1:0]   upd_mid;
    logic [`W_UPD_LOW-1:0]    upd_lo;
    word_kind_t               kind;
    logic                     end_flag;
    logic                     len_err;
    logic [`W_WORD-1:0]       word;
  } framer_state_t;
endpackage : framer_pkg

// File: verilog/word_stream_if.sv
// Purpose: valid/ready word carrier between framer and fifo
// Assumes: one clock
// Notes:   transfer when valid and ready are both high
`timescale 1ns/100ps
interface word_stream_if #(parameter int W = 40);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : word_stream_if

// File: verilog/word_fifo.sv
// Purpose: word buffer with valid/ready on both sides
// Assumes: DEPTH a power of two
// Notes:   output data read from a flop slot by index
`timescale 1ns/100ps
module word_fifo
#(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16
)
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  word_stream_if.snk                    in_s,
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic [WIDTH-1:0]              out_data_o,
  output logic [$clog2(DEPTH+1)-1:0]    level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [LW-1:0]               cnt;
  } fifo_state_t;

  fifo_state_t q_r;
  fifo_state_t q_nxt;
  logic        push;
  logic        pop;

  assign in_s.ready  = (q_r.cnt != LW'(DEPTH));
  assign out_valid_o = (q_r.cnt != '0);
  assign out_data_o  = q_r.mem[q_r.rp];
  assign level_o     = q_r.cnt;
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    q_nxt = q_r;
    if (push)
    begin
      q_nxt.mem[q_r.wp] = in_s.data;
      q_nxt.wp          = q_r.wp + AW'(1);
    end
    if (pop)
    begin
      q_nxt.rp = q_r.rp + AW'(1);
    end
    if (push && !pop)
    begin
      q_nxt.cnt = q_r.cnt + LW'(1);
    end
    else if (pop && !push)
    begin
      q_nxt.cnt = q_r.cnt - LW'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_r <= '0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end
endmodule : word_fifo

// File: verilog/auth_order_word_framer.sv
// Purpose: builds 40-bit authentication control words for a mobile
// Assumes: classic single-cycle bus master, one clock
// Notes:   words leave through a 16-word buffer
//
// What this block does
// [R01] every word opens with two-bit type code
// [R02] challenge word carries two-bit digital colour code
// [R03] challenge word carries four-bit global action code
// [R04] challenge word carries low sixteen random bits
// [R05] end flag high only on final word
// [R06] overhead codes 100, 110, 111 by meaning; every challenge word here carries 100 (OHD_GLOBAL)
// [R07] overhead type field exactly three bits
// [R08] parity computed here, supplied parity ignored
// [R09] update words carry two-bit tone colour code
// [R10] first update word: top 24 random bits
// [R11] second update word: next 24 random bits
// [R12] third update word: low eight random bits
// [R13] 28 info bits then 12 parity bits
// [R14] fields of wrong length are rejected
`timescale 1ns/100ps
`include "framer_params.svh"
module auth_order_word_framer
  import framer_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [7:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic [31:0]               dat_o,
  output logic                      ack_o,
  output logic                      word_valid_o,
  input  wire logic                 word_ready_i,
  output logic [`W_WORD-1:0]        word_data_o
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] merge_bytes
  (
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  // remainder of info * x^12 by the generator
  function automatic logic [`W_PAR-1:0] calc_parity
  (
    input logic [`W_INFO-1:0] info
  );
    logic [`W_PAR-1:0] p;
    logic              fb;
    p = '0;
    for (int i = `W_INFO-1; i >= 0; i--)
    begin
      fb = info[i] ^ p[`W_PAR-1];
      p  = {p[`W_PAR-2:0], 1'b0};
      if (fb)
      begin
        p = p ^ `PARITY_POLY;
      end
    end
    return p;
  endfunction : calc_parity

  function automatic logic [`W_WORD-1:0] build_word
  (
    input framer_state_t s
  );
    logic [`W_INFO-1:0] info;
    case (s.kind)
      // [R02] [R03] [R04] challenge fields
      // [R05] [R06] [R07] end flag, fixed overhead code
      KIND_CHAL_B:
        info = {s.type_code, s.color, s.act,
                s.chal[`W_CHAL_LOW-1:0], s.end_flag, `OHD_GLOBAL};
      // [R09] [R10] top part of update random
      KIND_UPD_ONE:
        info = {s.type_code, s.color, s.upd_hi};
      // [R11] following part of update random
      KIND_UPD_TWO:
        info = {s.type_code, s.color, s.upd_mid};
      // [R12] low part between reserved zeros
      KIND_UPD_THR:
        info = {s.type_code, s.color, `W_RSVD_A'(0), s.upd_lo,
                `W_RSVD_B'(0)};
      default:
        info = '0;
    endcase
    // [R01] [R13] type first, parity appended
    return {info, calc_parity(info)};
  endfunction : build_word

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  framer_state_t q_r;
  framer_state_t q_nxt;
  logic [31:0]   cur_v;
  logic [31:0]   wv;
  logic          access;
  logic          cmd_wr;
  logic          stall;
  logic [`W_LEVEL-1:0] level;

  word_stream_if #(.W(`W_WORD)) push_s ();

  assign access = cyc_i && stb_i && !q_r.ack;
  assign cmd_wr = access && we_i && (adr_i == `OFS_CMD);
  // a command waits while the previous word is not yet buffered
  assign stall  = cmd_wr && (q_r.st != ST_IDLE);
  assign wv     = merge_bytes(cur_v, dat_i, sel_i);

  assign push_s.valid = (q_r.st == ST_PUSH);
  assign push_s.data  = q_r.word;
  assign ack_o        = q_r.ack;
  assign dat_o        = q_r.rdat;

  // ------------------------------------------------------------
  // read view
  // ------------------------------------------------------------
  always_comb
  begin
    cur_v = '0;
    case (adr_i)
      `OFS_CMD:
      begin
        cur_v[`CMD_KIND_LSB +: `W_KIND] = q_r.kind;
        cur_v[`CMD_END_BIT]             = q_r.end_flag;
      end
      `OFS_FIELDS:
      begin
        cur_v[`W_TYPE-1:0]                = q_r.type_code;
        cur_v[`FLD_COLOR_LSB +: `W_COLOR] = q_r.color;
        cur_v[`FLD_ACT_LSB +: `W_ACT]     = q_r.act;
      end
      `OFS_CHAL:    cur_v = q_r.chal;
      `OFS_UPD_HI:  cur_v[`W_UPD_PART-1:0] = q_r.upd_hi;
      `OFS_UPD_MID: cur_v[`W_UPD_PART-1:0] = q_r.upd_mid;
      `OFS_UPD_LO:  cur_v[`W_UPD_LOW-1:0]  = q_r.upd_lo;
      `OFS_STATUS:
      begin
        cur_v[`ST_BUSY_BIT]                = (q_r.st != ST_IDLE);
        cur_v[`ST_ERR_BIT]                 = q_r.len_err;
        cur_v[`ST_LEVEL_LSB +: `W_LEVEL]   = level;
      end
      default:      cur_v = '0;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    q_nxt     = q_r;
    q_nxt.ack = access && !stall;
    if (access && !stall)
    begin
      q_nxt.rdat = we_i ? 32'h0000_0000 : cur_v;
    end

    case (q_r.st)
      ST_PUSH:
      begin
        if (push_s.ready)
        begin
          q_nxt.st = ST_IDLE;
        end
      end
      ST_IDLE: q_nxt.st = ST_IDLE;
      default: q_nxt.st = ST_IDLE;
    endcase

    if (access && !stall && we_i)
    begin
      case (adr_i)
        `OFS_CMD:
        begin
          // [R14] bits beyond the field refuse the write
          if (wv[31:`W_CMD] != '0)
          begin
            q_nxt.len_err = 1'b1;
          end
          else
          begin
            q_nxt.kind     = word_kind_t'(wv[`CMD_KIND_LSB +: `W_KIND]);
            q_nxt.end_flag = wv[`CMD_END_BIT];
            if (wv[`CMD_GO_BIT])
            begin
              q_nxt.word = build_word(q_nxt);
              q_nxt.st   = ST_PUSH;
            end
          end
        end
        `OFS_FIELDS:
        begin
          // [R14] length check on type, colour, action
          if (wv[31:`W_FIELDS] != '0)
          begin
            q_nxt.len_err = 1'b1;
          end
          else
          begin
            q_nxt.type_code = wv[`W_TYPE-1:0];
            q_nxt.color     = wv[`FLD_COLOR_LSB +: `W_COLOR];
            q_nxt.act       = wv[`FLD_ACT_LSB +: `W_ACT];
          end
        end
        `OFS_CHAL: q_nxt.chal = wv;
        `OFS_UPD_HI:
        begin
          // [R14] length check on random parts
          if (wv[31:`W_UPD_PART] != '0)
          begin
            q_nxt.len_err = 1'b1;
          end
          else
          begin
            q_nxt.upd_hi = wv[`W_UPD_PART-1:0];
          end
        end
        `OFS_UPD_MID:
        begin
          if (wv[31:`W_UPD_PART] != '0)
          begin
            q_nxt.len_err = 1'b1;
          end
          else
          begin
            q_nxt.upd_mid = wv[`W_UPD_PART-1:0];
          end
        end
        `OFS_UPD_LO:
        begin
          if (wv[31:`W_UPD_LOW] != '0)
          begin
            q_nxt.len_err = 1'b1;
          end
          else
          begin
            q_nxt.upd_lo = wv[`W_UPD_LOW-1:0];
          end
        end
        // [R08] supplied parity accepted and dropped
        `OFS_PARITY: q_nxt.len_err = q_r.len_err;
        `OFS_STATUS:
        begin
          // write one to clear the length error
          if (wv[`ST_ERR_BIT])
          begin
            q_nxt.len_err = 1'b0;
          end
        end
        default: q_nxt.len_err = q_r.len_err;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_r      <= '0;
      q_r.st   <= ST_IDLE;
      q_r.kind <= KIND_CHAL_B;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // ------------------------------------------------------------
  // output buffer
  // ------------------------------------------------------------
  word_fifo
  #(
    .WIDTH (`W_WORD),
    .DEPTH (`FIFO_DEPTH)
  )
  u_fifo
  (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_s        (push_s.snk),
    .out_valid_o (word_valid_o),
    .out_ready_i (word_ready_i),
    .out_data_o  (word_data_o),
    .level_o     (level)
  );
endmodule : auth_order_word_framer

// File: sim/framer_sva.sv
// Purpose: port checks of the word framer
// Assumes: framer_params.svh on the include path
// Notes:   bound to every framer instance
`timescale 1ns/100ps
`include "framer_params.svh"
module framer_sva
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        word_valid_o,
  input wire logic        word_ready_i,
  input wire logic [39:0] word_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence go_wr;
    cyc_i && stb_i && we_i && ack_o && adr_i == `OFS_CMD && dat_i[0] &&
    dat_i[31:`W_CMD] == 28'h0;
  endsequence
  chk_go_word: assert property (go_wr |-> ##[0:2] word_valid_o)
    else $error("no word after go");
  chk_valid_hold: assert property (
    word_valid_o && !word_ready_i |=> word_valid_o)
    else $error("word valid dropped");
  chk_word_hold: assert property (
    word_valid_o && !word_ready_i |=> $stable(word_data_o))
    else $error("word changed while held");
  chk_parity_zero: assert property (ack_o && !we_i &&
    (adr_i == `OFS_PARITY || adr_i > 8'h1C) |-> dat_o == 32'h0)
    else $error("parity or unmapped read not zero");
  chk_wr_zero: assert property (ack_o && we_i |-> dat_o == 32'h0)
    else $error("write ack with data");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property ($rose(ack_o) |->
    $past(cyc_i) && $past(stb_i))
    else $error("ack without request");
  chk_reset_quiet: assert property (disable iff (1'h0)
    rst_i |=> !ack_o && !word_valid_o)
    else $error("outputs active in reset");
endmodule : framer_sva
bind auth_order_word_framer framer_sva u_sva (.clk_i, .rst_i, .cyc_i,
  .stb_i, .we_i, .adr_i, .dat_i, .dat_o, .ack_o, .word_valid_o,
  .word_ready_i, .word_data_o);

// File: sim/mobile_word_sink.sv
// Purpose: mobile side taking framed words
// Assumes: one clock, valid/ready stream
// Notes:   ready prompt, pseudo random or stalled
`timescale 1ns/100ps
module mobile_word_sink
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        stall_i,
  input  wire logic        slow_i,
  input  wire logic        valid_i,
  input  wire logic [39:0] data_i,
  output logic             ready_o,
  output logic             got_o,
  output logic [39:0]      word_o
);
  logic [7:0] lfsr_r;
  always_ff @(posedge clk_i)
    if (rst_i)
      lfsr_r <= 8'h5A;
    else
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
  assign ready_o = !rst_i && !stall_i && (!slow_i || lfsr_r[0]);
  assign got_o   = valid_i && ready_o;
  assign word_o  = data_i;
endmodule : mobile_word_sink

// File: sim/test_auth_order_word_framer.sv
// Purpose: self-checking bench of the word framer
// Assumes: framer_params.svh on the include path
// Notes:   words checked as the sink takes them
`timescale 1ns/100ps
`include "framer_params.svh"
module test_auth_order_word_framer;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic        ack_o, word_valid_o, word_ready_i, stall = 0, slow = 0, got;
  logic [39:0] word_data_o, got_w, e;
  logic [39:0] expq[$];
  int          bad_count = 0, compares = 0, cycles = 0;
  auth_order_word_framer uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .word_valid_o,
    .word_ready_i, .word_data_o);
  mobile_word_sink sink (.clk_i, .rst_i, .stall_i(stall), .slow_i(slow),
    .valid_i(word_valid_o), .data_i(word_data_o), .ready_o(word_ready_i),
    .got_o(got), .word_o(got_w));
  initial forever #12.5 clk_i = ~clk_i;
  task automatic check(input string nm, input logic [39:0] s, x);
    compares++;
    if (s !== x)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'h1);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask : wb
  task automatic tally_and_finish();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  function automatic logic [39:0] mk(input logic [1:0] k,
    input logic [7:0] f, input logic [31:0] ch,
    input logic [23:0] hi, mid, input logic [7:0] lo, input logic en);
    logic [27:0] inf;
    logic [11:0] r;
    logic [3:0]  tc;
    tc = {f[1:0], f[3:2]};
    case (k)
      2'h0: inf = {tc, f[7:4], ch[15:0], en, `OHD_GLOBAL};
      2'h1: inf = {tc, hi};
      2'h2: inf = {tc, mid};
      default: inf = {tc, 12'h000, lo, 4'h0};
    endcase
    r = 12'h000;
    for (int i = 27; i >= 0; i--)
      r = {r[10:0], 1'h0} ^ ((inf[i] ^ r[11]) ? `PARITY_POLY : 12'h000);
    return {inf, r};
  endfunction : mk
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
    if (got === 1'h1)
    begin
      e = expq.size() ? expq.pop_front() : 40'h0;
      check("type colour", got_w[39:36], e[39:36]);
      check("fields", got_w[35:12], e[35:12]);
      check("word", got_w, e);
      check("parity", got_w[11:0], e[11:0]);
    end
  end
  task automatic drain();
    for (int n = 0; n < 600 && expq.size() != 0; n++) @(posedge clk_i);
    check("queue left", expq.size(), 0);
  endtask : drain
  initial
  begin
    logic [31:0] q, ch;
    logic [23:0] hi, mid;
    logic [7:0]  f, lo;
    logic [1:0]  k;
    logic        en;
    void'($urandom(26925));
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    wb(0, `OFS_STATUS, 32'h0, q);
    check("status reset", q, 32'h0);
    for (int i = 0; i < 40; i++)
    begin
      f = $urandom;
      ch = $urandom;
      hi = $urandom;
      mid = $urandom;
      lo = $urandom;
      en = $urandom;
      k = i % 4;
      if (i == 0)
      begin
        f = 8'hFF;
        ch = 32'hFFFF0000;
      end
      slow <= i[2];
      // words 24 to 39 stay put: exactly a full buffer
      stall <= (i >= 25);
      wb(1, `OFS_FIELDS, {24'h0, f}, q);
      wb(1, `OFS_CHAL, ch, q);
      wb(1, `OFS_UPD_HI, {8'h0, hi}, q);
      wb(1, `OFS_UPD_MID, {8'h0, mid}, q);
      wb(1, `OFS_UPD_LO, {24'h0, lo}, q);
      wb(1, `OFS_PARITY, $urandom, q);
      wb(1, `OFS_CMD, {28'h0, en, k, 1'h1}, q);
      expq.push_back(mk(k, f, ch, hi, mid, lo, en));
    end
    wb(0, `OFS_STATUS, 32'h0, q);
    check("full level", q, 32'h100);
    stall <= 0;
    drain();
    wb(1, `OFS_FIELDS, 32'h100, q);
    wb(0, `OFS_FIELDS, 32'h0, q);
    check("fields kept", q, {24'h0, f});
    wb(0, `OFS_STATUS, 32'h0, q);
    check("length error", q, 32'h2);
    wb(1, `OFS_STATUS, 32'h2, q);
    wb(0, `OFS_STATUS, 32'h0, q);
    check("error cleared", q, 32'h0);
    wb(1, `OFS_CMD, 32'h11, q);
    wb(0, `OFS_STATUS, 32'h0, q);
    check("cmd refused", q, 32'h2);
    wb(1, `OFS_STATUS, 32'h2, q);
    wb(1, 8'h40, 32'hFFFFFFFF, q);
    wb(0, 8'h40, 32'h0, q);
    check("unmapped", q, 32'h0);
    wb(0, `OFS_PARITY, 32'h0, q);
    check("parity reg", q, 32'h0);
    sel_i <= 4'h1;
    wb(1, `OFS_CHAL, 32'hA5A5A5A5, q);
    sel_i <= 4'hF;
    wb(0, `OFS_CHAL, 32'h0, q);
    check("byte lane", q, {ch[31:8], 8'hA5});
    tally_and_finish();
  end
endmodule : test_auth_order_word_framer
